// >>> include/ccs_pkg.sv
// Package for the control/status register bank of the integer unit.
// Assumes one core clock domain; shared by the register bank and its trap sequencer.
package ccs_pkg;
  localparam int NWIN_DEF       = 8;
  localparam int IMPL_LSB       = 28;
  localparam int VER_LSB        = 24;
  localparam int ICC_LSB        = 20;
  localparam int EC_BIT         = 13;
  localparam int EF_BIT         = 12;
  localparam int PIL_LSB        = 8;
  localparam int S_BIT          = 7;
  localparam int PS_BIT         = 6;
  localparam int ET_BIT         = 5;
  localparam int CWP_LSB        = 0;
  localparam int TBA_LSB        = 12;
  localparam int TT_LSB         = 4;
  localparam logic [3:0] IMPL_CODE = 4'hA; // Arbitrary value
  localparam logic [3:0] VER_CODE  = 4'h5; // Arbitrary value
  localparam logic [3:0] PIL_RST   = 4'hF;
  localparam logic [3:0] ICC_RST   = 4'h0;
  localparam logic [7:0] TT_RST    = 8'h00;
  localparam logic [19:0] TBA_RST  = 20'h00000;
  localparam logic [7:0] TT_FP_DIS = 8'h04;
  localparam logic [7:0] TT_WOVF   = 8'h05;
  localparam logic [7:0] TT_WUNF   = 8'h06;
  localparam logic [7:0] TT_IRQ0   = 8'h10;
  localparam logic [31:0] RESET_VEC = 32'h00000000;
  // Register selects
  typedef enum logic [1:0] {
    CCS_SEL_STATE = 2'h0,
    CCS_SEL_WIM   = 2'h1,
    CCS_SEL_TBR   = 2'h2,
    CCS_SEL_Y     = 2'h3
  } ccs_sel_t;
  // Processor mode, one-hot
  typedef enum logic [1:0] {
    CCS_EXEC  = 2'b01,
    CCS_ERROR = 2'b10
  } ccs_mode_t;
endpackage : ccs_pkg

// >>> include/ccs_trap_if.sv
// Interface carrying trap decisions between the register bank and its sequencer.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface ccs_trap_if;
  logic       take;
  logic [7:0] ttype;
  logic       halt;
  logic       et;
  logic [3:0] interrupt_level_mask;
  logic       sync_req;
  logic [7:0] sync_tt;
  logic       async_req;
  logic [3:0] irq_lvl;
  modport bank (output et, interrupt_level_mask, sync_req, sync_tt, async_req, irq_lvl, input take, ttype, halt);
  modport seq  (input et, interrupt_level_mask, sync_req, sync_tt, async_req, irq_lvl, output take, ttype, halt);
endinterface : ccs_trap_if

// >>> tb/ccs_regs_properties.sv
// Port checker for the control/status register bank.
// Assumes one core clock domain and the bind at the foot.
`timescale 1ns/1ps
module ccs_regs_properties (
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              nrst,
  // Register access
  input wire logic              rd_en,
  input wire logic              wr_en,
  input wire ccs_pkg::ccs_sel_t sel,
  input wire logic [31:0]       rd_data,
  input wire logic              priv_fault,
  // Trap and status
  input wire logic              trap_taken,
  input wire logic [31:0]       trap_pc,
  input wire logic              error_mode,
  input wire logic              supervisor
);
  import ccs_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  // Error mode refuses only writes; reads and priv_fault still answer, yet it is kept out of the fault cause
  logic uacc;
  assign uacc = (rd_en || wr_en) && !supervisor && sel != CCS_SEL_Y && !error_mode;
  a_err_sticky: assert property (error_mode |=> error_mode)
    else $error("error mode dropped without reset");
  a_err_no_trap: assert property (error_mode |-> !trap_taken)
    else $error("trap taken in error mode");
  a_trap_single: assert property (trap_taken |=> !trap_taken)
    else $error("trap taken twice in a row");
  a_trap_super: assert property (trap_taken |-> ##[0:1] supervisor)
    else $error("trap did not enter supervisor mode");
  a_tbr_low: assert property (trap_taken |-> trap_pc[3:0] == 4'h0)
    else $error("trap address low bits not zero");
  a_pc_hold: assert property (!trap_taken |-> $stable(trap_pc))
    else $error("trap address changed without a trap");
  a_user_fault: assert property (uacc |=> priv_fault)
    else $error("user access to privileged register not refused");
  a_user_nodata: assert property (uacc && rd_en |=> rd_data == 32'h0)
    else $error("user read of privileged register returned data");
  a_y_open: assert property ((rd_en || wr_en) && sel == CCS_SEL_Y |=> !priv_fault)
    else $error("multiply extension access faulted");
  a_rd_idle: assert property (!rd_en |=> rd_data == 32'h0)
    else $error("read data not zero when idle");
  c_trap: cover property (trap_taken);
  c_fault: cover property (priv_fault);
  c_err: cover property ($rose(error_mode));
endmodule : ccs_regs_properties

bind ccs_regs ccs_regs_properties u_props (.core_clk(core_clk), .nrst(nrst), .rd_en(rd_en),
  .wr_en(wr_en), .sel(sel), .rd_data(rd_data), .priv_fault(priv_fault),
  .trap_taken(trap_taken), .trap_pc(trap_pc), .error_mode(error_mode),
  .supervisor(supervisor));

// >>> tb/test_ccs_regs.sv
// Self-checking bench for the control/status register bank.
// Assumes a 25 MHz core clock; inputs change on the falling edge.
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module test_ccs_regs;
  import ccs_pkg::*;
  localparam logic [31:0] ID = {IMPL_CODE, VER_CODE, 24'h000000};
  localparam logic [19:0] TB = 20'hFFFFF;
  logic core_clk, nrst, rd_en, wr_en, save_op, restore_op, return_from_trap_op, icc_we;
  logic float_op, fpu_present_pin, sync_trap, priv_fault, trap_taken, pf, seen;
  logic error_mode, supervisor, fpu_enable_o;
  ccs_sel_t sel;
  logic [31:0] wr_data, rd_data, trap_pc, got;
  logic [7:0] sync_tt;
  logic [3:0] icc_in, irq_level_pin;
  int failures, comparisons;
  ccs_regs #(.NWIN(8)) uut (.core_clk(core_clk), .nrst(nrst), .rd_en(rd_en), .wr_en(wr_en),
    .sel(sel), .wr_data(wr_data), .rd_data(rd_data), .priv_fault(priv_fault),
    .save_op(save_op), .restore_op(restore_op), .return_from_trap_op(return_from_trap_op), .icc_we(icc_we),
    .icc_in(icc_in), .float_op(float_op), .fpu_present_pin(fpu_present_pin),
    .sync_trap(sync_trap), .sync_tt(sync_tt), .irq_level_pin(irq_level_pin),
    .trap_taken(trap_taken), .trap_pc(trap_pc), .error_mode(error_mode),
    .supervisor(supervisor), .fpu_enable_o(fpu_enable_o));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic rst;
    nrst = 1'b0;
    repeat (3) @(negedge core_clk);
    nrst = 1'b1;
  endtask : rst
  task automatic wr(input ccs_sel_t s, input logic [31:0] d);
    @(negedge core_clk);
    sel = s;
    wr_data = d;
    wr_en = 1'b1;
    @(negedge core_clk);
    wr_en = 1'b0;
  endtask : wr
  // Data and fault are taken at the falling edge after the answering edge
  task automatic rd(input ccs_sel_t s);
    @(negedge core_clk);
    sel = s;
    rd_en = 1'b1;
    @(negedge core_clk);
    rd_en = 1'b0;
    got = rd_data;
    pf = priv_fault;
  endtask : rd
  task automatic pulse(ref logic p);
    @(negedge core_clk);
    p = 1'b1;
    @(negedge core_clk);
    p = 1'b0;
  endtask : pulse
  // Bounded wait; a missing trap shows up as a stale trap address
  task automatic wait_trap;
    for (int n = 0; n < 8 && trap_taken !== 1'b1; n++) @(negedge core_clk);
  endtask : wait_trap
  task automatic quiet(input int n);
    seen = 1'b0;
    repeat (n) @(negedge core_clk) seen |= (trap_taken === 1'b1);
  endtask : quiet
  task automatic t_reset;
    `CHK("supervisor", 1'b1, supervisor)
    `CHK("trap_pc", 32'h0, trap_pc)
    rd(CCS_SEL_STATE);
    `CHK("state", ID | 32'h00000FC0, got)
  endtask : t_reset
  task automatic t_regs;
    wr(CCS_SEL_TBR, 32'hFFFFFFFF);
    rd(CCS_SEL_TBR);
    `CHK("tbr", 32'hFFFFF000, got)
    wr(CCS_SEL_WIM, 32'hFFFFFFFF);
    rd(CCS_SEL_WIM);
    `CHK("wim", 32'h000000FF, got)
    wr(CCS_SEL_Y, 32'h12345678);
    wr(CCS_SEL_STATE, 32'h000013E2);
    rd(CCS_SEL_STATE);
    `CHK("state", ID | 32'h000013E2, got)
    `CHK("fpu_en", 1'b1, fpu_enable_o)
  endtask : t_regs
  task automatic t_sync;
    sync_tt = 8'h2A;
    pulse(sync_trap);
    wait_trap();
    `CHK("trap_pc", {TB, 8'h2A, 4'h0}, trap_pc)
    rd(CCS_SEL_STATE);
    `CHK("state", ID | 32'h000013C1, got)
    rd(CCS_SEL_TBR);
    `CHK("tbr", 32'hFFFFF2A0, got)
  endtask : t_sync
  task automatic t_irq;
    irq_level_pin = 4'hF;
    quiet(8);
    `CHK("irq_off", 1'b0, seen)
    irq_level_pin = 4'h3;
    wr(CCS_SEL_STATE, 32'h000013E1);
    quiet(8);
    `CHK("irq_eq", 1'b0, seen)
    irq_level_pin = 4'h4;
    wait_trap();
    `CHK("trap_pc", {TB, 8'h14, 4'h0}, trap_pc)
    irq_level_pin = 4'h0;
  endtask : t_irq
  // Save from window 0 wraps onto window 7, which is marked invalid
  task automatic t_wovf;
    wr(CCS_SEL_WIM, 32'h00000080);
    wr(CCS_SEL_STATE, 32'h000013E0);
    pulse(save_op);
    wait_trap();
    `CHK("trap_pc", {TB, TT_WOVF, 4'h0}, trap_pc)
  endtask : t_wovf
  task automatic t_user;
    fpu_present_pin = 1'b0;
    wr(CCS_SEL_STATE, 32'h00001027);
    @(negedge core_clk);
    `CHK("supervisor", 1'b0, supervisor)
    rd(CCS_SEL_STATE);
    `CHK("fault", 1'b1, pf)
    `CHK("state", 32'h0, got)
    rd(CCS_SEL_Y);
    `CHK("y", 32'h12345678, got)
    pulse(float_op);
    wait_trap();
    `CHK("trap_pc", {TB, TT_FP_DIS, 4'h0}, trap_pc)
    @(negedge core_clk);
    `CHK("supervisor", 1'b1, supervisor)
    icc_in = 4'hA;
    pulse(icc_we);
    rd(CCS_SEL_STATE);
    `CHK("state_icc", ID | 32'h00A01086, got)
  endtask : t_user
  task automatic t_err;
    pulse(sync_trap);
    repeat (3) @(negedge core_clk);
    `CHK("error_mode", 1'b1, error_mode)
    rst();
    rd(CCS_SEL_WIM);
    `CHK("wim", 32'h00000080, got)
  endtask : t_err
  task automatic close_out;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  initial begin
    #200us;
    failures++;
    close_out();
  end
  initial begin
    {rd_en, wr_en, save_op, restore_op, return_from_trap_op, icc_we, float_op, sync_trap} = '0;
    {wr_data, sync_tt, icc_in, irq_level_pin} = '0;
    sel = CCS_SEL_STATE;
    fpu_present_pin = 1'b1;
    failures = 0;
    comparisons = 0;
    rst();
    t_reset();
    t_regs();
    t_sync();
    t_irq();
    t_wovf();
    t_user();
    t_err();
    close_out();
  end
endmodule : test_ccs_regs

// >>> verilog/ccs_regs.sv
// Control/status register bank of the integer unit.
// Assumes the pipeline presents one decoded instruction event per cycle.
`timescale 1ns/1ps
module ccs_regs #(
  parameter int NWIN = ccs_pkg::NWIN_DEF
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              nrst,
  // Register access port
  input  wire logic              rd_en,
  input  wire logic              wr_en,
  input  wire ccs_pkg::ccs_sel_t sel,
  input  wire logic [31:0]       wr_data,
  output logic [31:0]            rd_data,
  output logic                   priv_fault,
  // Pipeline events and pin inputs
  input  wire logic              save_op,
  input  wire logic              restore_op,
  input  wire logic              return_from_trap_op,
  input  wire logic              icc_we,
  input  wire logic [3:0]        icc_in,
  input  wire logic              float_op,
  input  wire logic              fpu_present_pin,
  input  wire logic              sync_trap,
  input  wire logic [7:0]        sync_tt,
  input  wire logic [3:0]        irq_level_pin,
  // Trap and status outputs
  output logic                   trap_taken,
  output logic [31:0]            trap_pc,
  output logic                   error_mode,
  output logic                   supervisor,
  output logic                   fpu_enable_o
);
  import ccs_pkg::*;
  localparam int CW = 5;

  function automatic logic [CW-1:0] wrap_inc(input logic [CW-1:0] v);
    wrap_inc = (v == CW'(NWIN - 1)) ? '0 : v + 1'b1;
  endfunction : wrap_inc
  function automatic logic [CW-1:0] wrap_dec(input logic [CW-1:0] v);
    wrap_dec = (v == '0) ? CW'(NWIN - 1) : v - 1'b1;
  endfunction : wrap_dec

  localparam logic [31:0] WIM_IMPL = 32'((64'h1 << NWIN) - 64'h1);

  logic [3:0]    icc_q;
  logic          ec_q, ef_q, s_q, ps_q, et_q;
  logic [3:0]    pil_q;
  logic [CW-1:0] cwp_q;
  logic [31:0]   wim_q;
  logic [19:0]   tba_q;
  logic [7:0]    tt_q;
  logic [31:0]   y_q;
  ccs_mode_t     mode_q;
  logic [1:0]    fp_sync_q;
  logic [3:0]    irq_s1_q, irq_s2_q;

  // Pin inputs through two flops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fp_sync_q <= 2'b00;
      irq_s1_q  <= 4'h0;
      irq_s2_q  <= 4'h0;
    end else begin
      fp_sync_q <= {fp_sync_q[0], fpu_present_pin};
      irq_s1_q  <= irq_level_pin;
      irq_s2_q  <= irq_s1_q;
    end
  end
  logic executing, priv_ok, state_wr, wim_wr, tbr_wr, y_wr;
  logic fp_dis, wovf, wunf;
  logic [CW-1:0] cwp_dn, cwp_up;
  logic [31:0] psr_view;

  assign executing = (mode_q == CCS_EXEC);
  assign priv_ok   = s_q || (sel == CCS_SEL_Y);
  assign state_wr  = executing && wr_en && priv_ok && (sel == CCS_SEL_STATE);
  assign wim_wr    = executing && wr_en && priv_ok && (sel == CCS_SEL_WIM);
  assign tbr_wr    = executing && wr_en && priv_ok && (sel == CCS_SEL_TBR);
  assign y_wr      = executing && wr_en && (sel == CCS_SEL_Y);
  assign cwp_dn    = wrap_dec(cwp_q);
  assign cwp_up    = wrap_inc(cwp_q);
  assign fp_dis    = float_op && !(ef_q && fp_sync_q[1]);
  assign wovf      = save_op && wim_q[cwp_dn];
  assign wunf      = (restore_op || return_from_trap_op) && wim_q[cwp_up];

  ccs_trap_if tif ();
  assign tif.et        = et_q;
  assign tif.interrupt_level_mask       = pil_q;
  assign tif.sync_req  = executing && (sync_trap || fp_dis || wovf || wunf);
  assign tif.sync_tt   = fp_dis ? TT_FP_DIS : wovf ? TT_WOVF : wunf ? TT_WUNF : sync_tt;
  assign tif.async_req = executing && (irq_s2_q != 4'h0);
  assign tif.irq_lvl   = irq_s2_q;

  ccs_trap_seq u_seq (
    .t (tif)
  );

  logic take;
  assign take = tif.take;

  // Execute / error mode
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) mode_q <= CCS_EXEC;
    else if (tif.halt) mode_q <= CCS_ERROR;
  end

  // Processor state register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      icc_q <= ICC_RST;
      ec_q  <= 1'b0;
      ef_q  <= 1'b0;
      pil_q <= PIL_RST;
      s_q   <= 1'b1;
      ps_q  <= 1'b1;
      et_q  <= 1'b0;
      cwp_q <= '0;
    end else if (take) begin
      s_q   <= 1'b1;
      ps_q  <= s_q;
      et_q  <= 1'b0;
      cwp_q <= cwp_dn;
    end else if (state_wr) begin
      icc_q <= wr_data[ICC_LSB +: 4];
      ec_q  <= wr_data[EC_BIT];
      ef_q  <= wr_data[EF_BIT];
      pil_q <= wr_data[PIL_LSB +: 4];
      s_q   <= wr_data[S_BIT];
      ps_q  <= wr_data[PS_BIT];
      et_q  <= wr_data[ET_BIT];
      cwp_q <= (wr_data[CWP_LSB +: CW] < CW'(NWIN)) ? wr_data[CWP_LSB +: CW] : cwp_q;
    end else if (executing) begin
      if (icc_we) icc_q <= icc_in;
      if (save_op) cwp_q <= cwp_dn;
      else if (restore_op) cwp_q <= cwp_up;
      else if (return_from_trap_op) begin
        cwp_q <= cwp_up;
        s_q   <= ps_q;
        et_q  <= 1'b1;
      end
    end
  end

  // Window invalid mask keeps its contents through reset
  always_ff @(posedge core_clk) begin
    if (wim_wr) wim_q <= wr_data & WIM_IMPL;
  end

  // Trap base register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tba_q <= TBA_RST;
      tt_q  <= TT_RST;
    end else begin
      if (tbr_wr) tba_q <= wr_data[TBA_LSB +: 20];
      if (take) tt_q <= tif.ttype;
    end
  end

  // Multiply-step extension
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) y_q <= 32'h00000000;
    else if (y_wr) y_q <= wr_data;
  end

  always_comb begin
    psr_view = 32'h00000000;
    psr_view[IMPL_LSB +: 4] = IMPL_CODE;
    psr_view[VER_LSB +: 4]  = VER_CODE;
    psr_view[ICC_LSB +: 4]  = icc_q;
    psr_view[EC_BIT]        = ec_q;
    psr_view[EF_BIT]        = ef_q;
    psr_view[PIL_LSB +: 4]  = pil_q;
    psr_view[S_BIT]         = s_q;
    psr_view[PS_BIT]        = ps_q;
    psr_view[ET_BIT]        = et_q;
    psr_view[CWP_LSB +: CW] = cwp_q;
  end

  // Read path and trap outputs, all registered
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data    <= 32'h00000000;
      priv_fault <= 1'b0;
    end else begin
      priv_fault <= (rd_en || wr_en) && !priv_ok;
      if (rd_en && priv_ok) begin
        unique case (sel)
          CCS_SEL_STATE: rd_data <= psr_view;
          CCS_SEL_WIM:   rd_data <= wim_q & WIM_IMPL;
          CCS_SEL_TBR:   rd_data <= {tba_q, tt_q, 4'h0};
          CCS_SEL_Y:     rd_data <= y_q;
        endcase
      end else begin
        rd_data <= 32'h00000000;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      trap_taken <= 1'b0;
      trap_pc    <= RESET_VEC;
      error_mode <= 1'b0;
      supervisor <= 1'b1;
      fpu_enable_o <= 1'b0;
    end else begin
      trap_taken <= take;
      if (take) trap_pc <= {tba_q, tif.ttype, 4'h0};
      error_mode <= (mode_q == CCS_ERROR) || tif.halt;
      supervisor <= take ? 1'b1 : s_q;
      fpu_enable_o <= ef_q;
    end
  end

endmodule : ccs_regs

// >>> verilog/ccs_trap_seq.sv
// Trap decision: picks synchronous over asynchronous, masks interrupts.
// Assumes requests arrive synchronous to core_clk.
`timescale 1ns/1ps
module ccs_trap_seq (
  ccs_trap_if.seq t
);
  import ccs_pkg::*;
  always_comb begin
    t.take  = 1'b0;
    t.halt  = 1'b0;
    t.ttype = t.sync_tt;
    if (t.sync_req) begin
      if (t.et) t.take = 1'b1;
      else t.halt = 1'b1;
    end else if (t.async_req && t.et && (t.irq_lvl > t.interrupt_level_mask)) begin
      t.take  = 1'b1;
      t.ttype = TT_IRQ0 | {4'h0, t.irq_lvl};
    end
  end
endmodule : ccs_trap_seq
